// ---- pid_cd_pkg.sv ----
// Purpose: Shared constants for the complete-derivative PID block
// Assumes: 200 MHz clock, byte addresses on the register bus
// Notes:   Coefficients are unsigned fixed point, 8 fraction bits
package pid_cd_pkg;
   // ===========================================================
   // Timing
   localparam int CLK_PERIOD_NS = 5;                // Core clock period
   localparam int TICK_NS       = 10_000_000;       // Sample period unit, 0.01 s
   localparam int TICK_CYCLES_DEF = TICK_NS / CLK_PERIOD_NS; // Cycles per unit
   // ===========================================================
   // Register byte offsets
   localparam logic [7:0] ADDR_CTRL   = 8'h00;      // Limits enable
   localparam logic [7:0] ADDR_SEL    = 8'h04;      // Loop index
   localparam logic [7:0] ADDR_CMD    = 8'h08;      // Resume / halt
   localparam logic [7:0] ADDR_RUN    = 8'h0C;      // Running mask
   localparam logic [7:0] ADDR_SETVAL = 8'h10;      // Set value
   localparam logic [7:0] ADDR_GAIN   = 8'h14;      // Proportional gain
   localparam logic [7:0] ADDR_INTEG  = 8'h18;      // Sample period over integral time
   localparam logic [7:0] ADDR_DERIV  = 8'h1C;      // Derivative time over sample period
   localparam logic [7:0] ADDR_FILTER = 8'h20;      // Filter coefficient
   localparam logic [7:0] ADDR_PERIOD = 8'h24;      // Sample period in units
   localparam logic [7:0] ADDR_DIR    = 8'h28;      // Direction
   localparam logic [7:0] ADDR_PVF    = 8'h2C;      // Filtered process value
   localparam logic [7:0] ADDR_MV     = 8'h30;      // Manipulated value
   // ===========================================================
   // Field positions
   localparam int CTRL_LIMIT_BIT = 0;
   localparam int CMD_RESUME_BIT = 0;
   localparam int CMD_HALT_BIT   = 1;
   localparam int DIR_REV_BIT    = 0;
   localparam int FRAC_BITS      = 8;                // Fraction bits of all coefficients
   // ===========================================================
   // Limits and reset values
   localparam logic signed [15:0] MV_LIM_LO  = 16'hFFCE;  // -50
   localparam logic signed [15:0] MV_LIM_HI  = 16'h0802;  // 2050
   localparam logic signed [15:0] S16_LO     = 16'h8000;
   localparam logic signed [15:0] S16_HI     = 16'h7FFF;
   localparam logic [15:0]        GAIN_RST   = 16'h0100;  // Gain 1.0
   localparam logic [15:0]        PERIOD_RST = 16'h0001;
   localparam logic [15:0]        ZERO16     = 16'h0000;
   localparam logic [31:0]        ZERO32     = 32'h0000_0000;
endpackage

// ---- pid_complete_derivative_loop.sv ----
// Purpose: Multi-loop incremental PID with derivative on filtered value
// Assumes: Samples arrive tagged with a loop index; one clock domain
// Notes:   Register bus is Avalon-MM, one answer cycle per request
//
// Added by the designer: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps

// ==============================================================
// Sample FIFO
module pid_fifo #(
   parameter int W     = 21,
   parameter int DEPTH = 4
) (
   input  wire logic         clock,
   input  wire logic         rst,
   input  wire logic         inValid,
   output logic              inReady,
   input  wire logic [W-1:0] inData,
   output logic              outValid,
   input  wire logic         outReady,
   output logic [W-1:0]      outData
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;     // Storage
      logic [AW:0]             count;   // Words held
      logic [AW-1:0]           rd;      // Read pointer
      logic [AW-1:0]           wr;      // Write pointer
      logic                    ready;   // Registered not-full
   } fifo_t;
   fifo_t s;
   fifo_t n;
   logic  push;
   logic  pop;
   function automatic logic [AW-1:0] wrap(input logic [AW-1:0] p);
      wrap = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
   endfunction
   assign outValid = (s.count != '0);
   assign outData  = s.mem[s.rd];
   assign inReady  = s.ready;
   // Next state of the FIFO
   always_comb begin
      n    = s;
      push = inValid && s.ready;
      pop  = outValid && outReady;
      if (push) begin
         n.mem[s.wr] = inData;
         n.wr        = wrap(s.wr);
      end
      if (pop) begin
         n.rd = wrap(s.rd);
      end
      n.count = (AW + 1)'(s.count + push - pop);
      n.ready = (n.count != (AW + 1)'(DEPTH));
   end
   // State register
   always_ff @(posedge clock) begin
      if (rst) begin
         s       <= '0;
         s.ready <= 1'b1;
      end else begin
         s <= n;
      end
   end
endmodule

// ==============================================================
// PID engine
// Overview of operation
// - Separate state per loop, 8 or 32
// - Derivative on filtered value, forward or reverse
// - Output clamped to range per limits setting
// - Deviation sign follows direction
// - Increment is gain times three-part sum
// - Derivative from second difference, reverse inverts
// - Filter mixes raw and previous filtered
// - Zero coefficient passes raw sample through
// - Filtered value stored and readable
// - Two filtered values, one deviation retained
// - Loops halted or resumed individually
module pid_complete_derivative_loop #(
   parameter int LOOPS       = 32,
   parameter int TICK_CYCLES = pid_cd_pkg::TICK_CYCLES_DEF,
   parameter int FIFO_DEPTH  = 4,
   parameter int LW          = $clog2(LOOPS)
) (
   input  wire logic          clock,
   input  wire logic          rst,
   input  wire logic [7:0]    avs_address,
   input  wire logic          avs_read,
   input  wire logic          avs_write,
   input  wire logic [31:0]   avs_writedata,
   output logic [31:0]        avs_readdata,
   output logic               avs_waitrequest,
   input  wire logic          pvValid,
   output logic               pvReady,
   input  wire logic [LW-1:0] pvLoop,
   input  wire logic [15:0]   pvData,
   output logic               mvValid,
   output logic [LW-1:0]      mvLoop,
   output logic [15:0]        mvData,
   output logic [15:0]        pvfData
);
   import pid_cd_pkg::*;

   // ===========================================================
   // State
   typedef enum logic [1:0] {S_IDLE, S_FILT, S_CALC} phase_t;
   typedef logic [LOOPS-1:0][15:0] arr_t;
   typedef struct packed {
      logic          waitReq;   // Bus wait, low for the answer cycle
      logic [31:0]   rdata;     // Read data
      logic          limitsEn;  // Output range select
      logic [LW-1:0] sel;       // Loop seen through the window
      logic [LOOPS-1:0] run;    // Loop running
      logic [LOOPS-1:0] due;    // Period elapsed, update owed
      logic [LOOPS-1:0] rev;    // Reverse direction
      arr_t          sv;        // Set values
      arr_t          kp;        // Gains
      arr_t          ki;        // Integral ratios
      arr_t          kd;        // Derivative ratios
      arr_t          alpha;     // Filter coefficients
      arr_t          period;    // Sample periods
      arr_t          cnt;       // Period countdown
      arr_t          pvf1;      // Previous filtered value
      arr_t          pvf2;      // Filtered value two updates back
      arr_t          ev1;       // Previous deviation
      arr_t          mv;        // Running output
      logic [31:0]   tick;      // Unit prescaler
      phase_t        phase;     // Engine step
      logic [LW-1:0] cur;       // Loop being computed
      logic [15:0]   raw;       // Raw sample
      logic [15:0]   pvf;       // Filtered sample
      logic          mvValid;
      logic [LW-1:0] mvLoop;
      logic [15:0]   mvData;
      logic [15:0]   pvfData;
   } state_t;
   state_t s;
   state_t n;
   logic          fValid;       // FIFO head present
   logic          fReady;       // Engine takes head
   logic [LW+15:0] fData;       // Loop index and sample
   // ===========================================================
   // Arithmetic helpers
   function automatic logic signed [31:0] mulShift(input logic signed [31:0] a,
                                                   input logic signed [31:0] b);
      logic signed [63:0] p;
      p        = a * b;
      mulShift = 32'(p >>> FRAC_BITS);
   endfunction
   function automatic logic [15:0] sat16(input logic signed [31:0] x,
                                         input logic signed [15:0] lo,
                                         input logic signed [15:0] hi);
      if (x < lo) begin
         sat16 = lo;
      end else if (x > hi) begin
         sat16 = hi;
      end else begin
         sat16 = x[15:0];
      end
   endfunction
   function automatic logic signed [31:0] sx(input logic [15:0] v);
      sx = 32'($signed(v));
   endfunction
   function automatic logic signed [31:0] zx(input logic [15:0] v);
      zx = $signed({ZERO16, v});
   endfunction
   // ===========================================================
   // Sample FIFO
   pid_fifo #(
      .W     (LW + 16),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clock    (clock),
      .rst      (rst),
      .inValid  (pvValid),
      .inReady  (pvReady),
      .inData   ({pvLoop, pvData}),
      .outValid (fValid),
      .outReady (fReady),
      .outData  (fData)
   );

   assign avs_readdata    = s.rdata;
   assign avs_waitrequest = s.waitReq;
   assign mvValid         = s.mvValid;
   assign mvLoop          = s.mvLoop;
   assign mvData          = s.mvData;
   assign pvfData         = s.pvfData;

   // ===========================================================
   // Next state: bus, engine, then period timers
   always_comb begin
      logic signed [31:0] ev;
      logic signed [31:0] d2;
      logic signed [31:0] inc;
      logic signed [15:0] lo;
      logic signed [15:0] hi;
      logic [LW-1:0]      fl;
      ev        = '0;
      d2        = '0;
      inc       = '0;
      lo        = s.limitsEn ? MV_LIM_LO : S16_LO;
      hi        = s.limitsEn ? MV_LIM_HI : S16_HI;
      fl        = fData[LW+15:16];
      n         = s;
      n.mvValid = 1'b0;
      fReady    = 1'b0;
      // Bus: accept while waiting, answer one cycle later
      if (s.waitReq) begin
         if (avs_read || avs_write) begin
            n.waitReq = 1'b0;
            case (avs_address)
               ADDR_CTRL:   n.rdata = 32'(s.limitsEn);
               ADDR_SEL:    n.rdata = 32'(s.sel);
               ADDR_RUN:    n.rdata = 32'(s.run);
               ADDR_SETVAL: n.rdata = {ZERO16, s.sv[s.sel]};
               ADDR_GAIN:   n.rdata = {ZERO16, s.kp[s.sel]};
               ADDR_INTEG:  n.rdata = {ZERO16, s.ki[s.sel]};
               ADDR_DERIV:  n.rdata = {ZERO16, s.kd[s.sel]};
               ADDR_FILTER: n.rdata = {ZERO16, s.alpha[s.sel]};
               ADDR_PERIOD: n.rdata = {ZERO16, s.period[s.sel]};
               ADDR_DIR:    n.rdata = 32'(s.rev[s.sel]);
               ADDR_PVF:    n.rdata = {ZERO16, s.pvf1[s.sel]};
               ADDR_MV:     n.rdata = {ZERO16, s.mv[s.sel]};
               default:     n.rdata = ZERO32;                    // Unmapped reads zero
            endcase
         end
      end else begin
         // Answer cycle: write lands here
         n.waitReq = 1'b1;
         if (avs_write) begin
            case (avs_address)
               ADDR_CTRL:   n.limitsEn = avs_writedata[CTRL_LIMIT_BIT];
               ADDR_SEL:    n.sel = avs_writedata[LW-1:0];
               ADDR_CMD: begin
                  if (avs_writedata[CMD_RESUME_BIT]) begin
                     n.run[s.sel] = 1'b1;
                     n.due[s.sel] = 1'b0;
                     n.cnt[s.sel] = s.period[s.sel];
                  end
                  if (avs_writedata[CMD_HALT_BIT]) begin
                     n.run[s.sel] = 1'b0;
                  end
               end
               ADDR_SETVAL: n.sv[s.sel]     = avs_writedata[15:0];
               ADDR_GAIN:   n.kp[s.sel]     = avs_writedata[15:0];
               ADDR_INTEG:  n.ki[s.sel]     = avs_writedata[15:0];
               ADDR_DERIV:  n.kd[s.sel]     = avs_writedata[15:0];
               ADDR_FILTER: n.alpha[s.sel]  = avs_writedata[15:0];
               ADDR_PERIOD: n.period[s.sel] = avs_writedata[15:0];
               ADDR_DIR:    n.rev[s.sel]    = avs_writedata[DIR_REV_BIT];
               default: begin
                  // Unmapped writes are ignored
               end
            endcase
         end
      end
      // Engine
      case (s.phase)
         S_IDLE: begin
            if (fValid) begin
               fReady = 1'b1;
               // Samples for halted or not-yet-due loops are dropped
               if (s.run[fl] && s.due[fl]) begin
                  n.cur     = fl;
                  n.raw     = fData[15:0];
                  n.due[fl] = 1'b0;
                  n.phase   = S_FILT;
               end
            end
         end
         S_FILT: begin
            // Zero coefficient leaves the raw sample untouched
            n.pvf   = sat16(sx(s.raw) + mulShift(zx(s.alpha[s.cur]),
                            sx(s.pvf1[s.cur]) - sx(s.raw)), S16_LO, S16_HI);
            n.phase = S_CALC;
         end
         S_CALC: begin
            ev = s.rev[s.cur] ? sx(s.sv[s.cur]) - sx(s.pvf)
                              : sx(s.pvf) - sx(s.sv[s.cur]);
            d2 = sx(s.pvf) - (sx(s.pvf1[s.cur]) <<< 1) + sx(s.pvf2[s.cur]);
            if (s.rev[s.cur]) begin
               d2 = -d2;
            end
            inc = mulShift(zx(s.kp[s.cur]), (ev - sx(s.ev1[s.cur]))
                  + mulShift(zx(s.ki[s.cur]), ev)
                  + mulShift(zx(s.kd[s.cur]), d2));
            n.mv[s.cur]   = sat16(sx(s.mv[s.cur]) + inc, lo, hi);
            n.pvf2[s.cur] = s.pvf1[s.cur];
            n.pvf1[s.cur] = s.pvf;
            n.ev1[s.cur]  = sat16(ev, S16_LO, S16_HI);
            n.mvValid     = 1'b1;
            n.mvLoop      = s.cur;
            n.mvData      = n.mv[s.cur];
            n.pvfData     = s.pvf;
            n.phase       = S_IDLE;
         end
         default: n.phase = S_IDLE;
      endcase
      // Period timers: placed last so a new period wins over a clear
      if (s.tick >= 32'(TICK_CYCLES - 1)) begin
         n.tick = ZERO32;
         for (int i = 0; i < LOOPS; i++) begin
            if (s.run[i]) begin
               if (s.cnt[i] <= 16'h0001) begin
                  n.cnt[i] = s.period[i];
                  n.due[i] = 1'b1;
               end else begin
                  n.cnt[i] = s.cnt[i] - 16'h0001;
               end
            end
         end
      end else begin
         n.tick = s.tick + 32'h0000_0001;
      end
   end
   // State register
   always_ff @(posedge clock) begin
      if (rst) begin
         s         <= '0;
         s.waitReq <= 1'b1;
         s.phase   <= S_IDLE;
         for (int i = 0; i < LOOPS; i++) begin
            s.kp[i]     <= GAIN_RST;
            s.period[i] <= PERIOD_RST;
         end
      end else begin
         s <= n;
      end
   end
   // ===========================================================
   // Checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   sequence filtThenCalc;
      s.phase == S_FILT ##1 s.phase == S_CALC ##1 s.mvValid;
   endsequence
   sequence busRequest;
      (avs_read || avs_write) && s.waitReq;
   endsequence
   a_bus_answer: assert property (busRequest |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("Bus answer not one cycle wide");
   a_mv_range: assert property (mvValid && s.limitsEn |->
         $signed(mvData) >= MV_LIM_LO && $signed(mvData) <= MV_LIM_HI)
      else $error("Output outside limited range");
   a_update_steps: assert property (s.phase == S_FILT |-> filtThenCalc)
      else $error("Update did not complete in two cycles");
   a_skip_idle: assert property (s.phase == S_IDLE && fValid &&
         !(s.run[fData[LW+15:16]] && s.due[fData[LW+15:16]]) |=> s.phase == S_IDLE)
      else $error("Sample for idle loop was computed");
   a_filter_bypass: assert property (s.phase == S_FILT && s.alpha[s.cur] == ZERO16
         |=> s.pvf == $past(s.raw))
      else $error("Raw sample altered without coefficient");
   a_pvf_stored: assert property (mvValid |-> s.pvf1[mvLoop] == pvfData &&
         s.pvf2[mvLoop] == $past(s.pvf1[s.cur]))
      else $error("Filtered history not shifted");
   a_dev_forward: assert property (s.phase == S_CALC && !s.rev[s.cur] &&
         s.pvf == s.sv[s.cur] |=> s.ev1[$past(s.cur)] == ZERO16)
      else $error("Deviation wrong when on set value");
   a_halt_clears: assert property (!s.waitReq && avs_write && avs_address == ADDR_CMD
         && avs_writedata[CMD_HALT_BIT] |=> !s.run[$past(s.sel)])
      else $error("Halt did not stop loop");
endmodule

// ---- pv_source_model.sv ----
// Purpose: Model of the measurement source and of the actuator sink
// Assumes: One clock; a sample is taken at an edge with valid and ready high
// Notes:   Released sample lines show the inverse of the last value
`timescale 1ns/1ps
module pv_source_model #(
   parameter int LW = 3
) (
   input  wire logic          clock,
   input  wire logic          pvReady,
   output logic               pvValid,
   output logic [LW-1:0]      pvLoop,
   output logic [15:0]        pvData,
   input  wire logic          mvValid,
   input  wire logic [LW-1:0] mvLoop,
   input  wire logic [15:0]   mvData,
   input  wire logic [15:0]   pvfData
);
   // ==========================================================
   // Capture of each output update
   int          nUpd     = 0;        // Updates seen
   logic [15:0] lastMv   = 16'h0000; // Output of the last update
   logic [15:0] lastPvf  = 16'h0000; // Filtered value of the last update
   logic [15:0] lastLoop = 16'h0000; // Loop of the last update
   int          nStall   = 0;        // Offers not taken within 200 cycles

   // Idle source at time zero
   initial begin
      pvValid = 1'b0;
      pvLoop  = '0;
      pvData  = 16'h0000;
   end

   // Output values stand in the pulse cycle only for the flag
   always @(posedge clock) begin
      if (mvValid === 1'b1) begin
         nUpd     = nUpd + 1;
         lastMv   = mvData;
         lastPvf  = pvfData;
         lastLoop = 16'(mvLoop);
      end
   end

   // ==========================================================
   // Offers one sample; keep leaves valid up for a follower
   task automatic push(input logic [LW-1:0] l, input logic [15:0] d, input bit keep);
      int n;
      n = 0;
      if (pvValid !== 1'b1) @(posedge clock);
      pvValid <= 1'b1;
      pvLoop  <= l;
      pvData  <= d;
      do begin
         @(posedge clock);
         n++;
      end while (pvReady !== 1'b1 && n < 200);
      if (n >= 200) nStall++;
      // Released lines must not keep showing the old sample
      if (!keep) begin
         pvValid <= 1'b0;
         pvLoop  <= ~l;
         pvData  <= ~d;
      end
   endtask
endmodule

// ---- tb.sv ----
// Purpose: Self-checking bench for the multi-loop PID block
// Assumes: 8 loops, 8 clock cycles per period unit
// Notes:   Expected values are worked out by hand from the update equations
`timescale 1ns/1ps
module tb;
   import pid_cd_pkg::*;
   // ==========================================================
   // Stimulus and observation signals
   logic        clock         = 1'b0;
   logic        rst           = 1'b1;
   logic [7:0]  avsAddress    = 8'h00;
   logic        avsRead       = 1'b0;
   logic        avsWrite      = 1'b0;
   logic [31:0] avsWritedata  = 32'h0000_0000;
   logic [31:0] avsReaddata;
   logic        avsWaitrequest;
   logic        pvValid, pvReady, mvValid;
   logic [2:0]  pvLoop, mvLoop;
   logic [15:0] pvData, mvData, pvfData;
   logic [31:0] rd;                // Last read data
   logic        sawFull   = 1'b0;  // FIFO refused at least once
   int          nFail     = 0;
   int          checksDone = 0;

   always #2.5 clock = ~clock;

   // Notes a refused sample
   always @(posedge clock) if (pvReady === 1'b0) sawFull <= 1'b1;

   pid_complete_derivative_loop #(.LOOPS(8), .TICK_CYCLES(8), .FIFO_DEPTH(4), .LW(3)) dut (
      .clock(clock), .rst(rst), .avs_address(avsAddress), .avs_read(avsRead),
      .avs_write(avsWrite), .avs_writedata(avsWritedata), .avs_readdata(avsReaddata),
      .avs_waitrequest(avsWaitrequest), .pvValid(pvValid), .pvReady(pvReady),
      .pvLoop(pvLoop), .pvData(pvData), .mvValid(mvValid), .mvLoop(mvLoop),
      .mvData(mvData), .pvfData(pvfData));

   pv_source_model #(.LW(3)) src (
      .clock(clock), .pvReady(pvReady), .pvValid(pvValid), .pvLoop(pvLoop),
      .pvData(pvData), .mvValid(mvValid), .mvLoop(mvLoop), .mvData(mvData),
      .pvfData(pvfData));

   // ==========================================================
   // Shared tasks
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checksDone++;
      if (seen !== exp) begin
         nFail++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // One bus cycle, held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock);
      avsAddress   <= a;
      avsWrite     <= w;
      avsRead      <= ~w;
      avsWritedata <= d;
      do begin
         @(posedge clock);
         n++;
      end while (avsWaitrequest !== 1'b0 && n < 50);
      rd = avsReaddata;
      avsWrite <= 1'b0;
      avsRead  <= 1'b0;
      if (n >= 50) nFail++;
   endtask

   task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000);
      check(what, rd, exp);
   endtask

   // Loads one loop and starts it
   task automatic cfg(input logic [15:0] l, sv, kp, ki, kd, al, dir, per);
      bus(1'b1, ADDR_SEL, {16'h0000, l});
      bus(1'b1, ADDR_SETVAL, {16'h0000, sv});
      bus(1'b1, ADDR_GAIN, {16'h0000, kp});
      bus(1'b1, ADDR_INTEG, {16'h0000, ki});
      bus(1'b1, ADDR_DERIV, {16'h0000, kd});
      bus(1'b1, ADDR_FILTER, {16'h0000, al});
      bus(1'b1, ADDR_DIR, {16'h0000, dir});
      bus(1'b1, ADDR_PERIOD, {16'h0000, per});
      bus(1'b1, ADDR_CMD, 32'h0000_0001);
      repeat (20) @(posedge clock);
   endtask

   task automatic waitUpd(input int target);
      int n;
      n = 0;
      while (src.nUpd < target && n < 40) begin
         @(posedge clock);
         n++;
      end
   endtask

   // One sample, then compare the update it produced
   task automatic sample(input logic [2:0] l, input logic [15:0] pv, mv, pvf);
      int b;
      b = src.nUpd;
      src.push(l, pv, 1'b0);
      waitUpd(b + 1);
      check("updates", src.nUpd, b + 1);
      check("mvData", {16'h0000, src.lastMv}, {16'h0000, mv});
      check("pvfData", {16'h0000, src.lastPvf}, {16'h0000, pvf});
      check("mvLoop", {16'h0000, src.lastLoop}, {29'h0, l});
      repeat (10) @(posedge clock);
   endtask

   // ==========================================================
   // Scenarios
   task automatic testReset;
      rdchk("gain", ADDR_GAIN, 32'h0000_0100);
      rdchk("period", ADDR_PERIOD, 32'h0000_0001);
      rdchk("running", ADDR_RUN, 32'h0000_0000);
      bus(1'b1, 8'h3C, 32'h0000_1234);
      rdchk("unmapped", 8'h3C, 32'h0000_0000);
      bus(1'b1, ADDR_SETVAL, 32'h0000_FFFB);
      rdchk("setval", ADDR_SETVAL, 32'h0000_FFFB);
   endtask

   task automatic testDeriv;
      cfg(16'h0001, 16'h0064, 16'h0100, 16'h0000, 16'h0100, 16'h0000, 16'h0000, 16'h0001);
      sample(3'h1, 16'h0096, 16'h00C8, 16'h0096);
      sample(3'h1, 16'h0096, 16'h0032, 16'h0096);
      sample(3'h1, 16'h0096, 16'h0032, 16'h0096);
      sample(3'h1, 16'h0064, 16'hFFCE, 16'h0064);
      rdchk("running", ADDR_RUN, 32'h0000_0002);
      bus(1'b1, ADDR_CMD, 32'h0000_0002);
      rdchk("halted", ADDR_RUN, 32'h0000_0000);
      repeat (20) @(posedge clock);
      src.push(3'h1, 16'h0096, 1'b0);
      repeat (30) @(posedge clock);
      check("no update", src.nUpd, 4);
   endtask

   task automatic testFilter;
      int b;
      cfg(16'h0002, 16'h0000, 16'h0100, 16'h0000, 16'h0000, 16'h0080, 16'h0000, 16'h0001);
      sample(3'h2, 16'h0064, 16'h0032, 16'h0032);
      sample(3'h2, 16'h0064, 16'h004B, 16'h004B);
      rdchk("pvf", ADDR_PVF, 32'h0000_004B);
      rdchk("mv", ADDR_MV, 32'h0000_004B);
      // Long period, then two samples inside it: only one counts
      bus(1'b1, ADDR_PERIOD, 32'h0000_0064);
      bus(1'b1, ADDR_CMD, 32'h0000_0001);
      repeat (820) @(posedge clock);
      b = src.nUpd;
      src.push(3'h2, 16'h0064, 1'b1);
      src.push(3'h2, 16'h0064, 1'b0);
      repeat (40) @(posedge clock);
      check("one update", src.nUpd, b + 1);
      check("floor mv", {16'h0000, src.lastMv}, 32'h0000_0057);
   endtask

   task automatic testLimits;
      bus(1'b1, ADDR_CTRL, 32'h0000_0001);
      cfg(16'h0003, 16'h07D0, 16'h0100, 16'h0100, 16'h0100, 16'h0000, 16'h0001, 16'h0001);
      cfg(16'h0007, 16'h03E8, 16'h0100, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0001);
      sample(3'h3, 16'h0032, 16'h0802, 16'h0032);
      sample(3'h7, 16'h0032, 16'hFFCE, 16'h0032);
      bus(1'b1, ADDR_CTRL, 32'h0000_0000);
      sample(3'h3, 16'h0032, 16'h0FD2, 16'h0032);
   endtask

   // Two computing loops then dropped samples fill the FIFO
   task automatic testFill;
      int b;
      b = src.nUpd;
      src.push(3'h3, 16'h0032, 1'b1);
      src.push(3'h7, 16'h0032, 1'b1);
      repeat (5) src.push(3'h5, 16'h0064, 1'b1);
      src.push(3'h5, 16'h0064, 1'b0);
      repeat (40) @(posedge clock);
      check("fifo full", {31'h0, sawFull}, 32'h0000_0001);
      check("fifo drained", {31'h0, pvReady}, 32'h0000_0001);
      check("burst updates", src.nUpd, b + 2);
      check("stalls", src.nStall, 0);
   endtask

   // ==========================================================
   // Verdict
   task automatic stopTest;
      $display("checks %0d failures %0d", checksDone, nFail);
      if (nFail == 0 && checksDone > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      testReset();
      testDeriv();
      testFilter();
      testLimits();
      testFill();
      stopTest();
   end

   // Watchdog, well past the expected run of under two thousand cycles
   initial begin
      #100000;
      nFail++;
      stopTest();
   end
endmodule
